// ==== timed_signal_functions.sv ====
// Off-delay, on-delay and single-button reset latch with AXI4-Lite setup.
// Function inputs come from other internal logic, synchronous to aclk.
//
// Overview of operation
// - Off output drops after input low delay
// - Off-delay passes rising edge undelayed
// - Off-delay time set in milliseconds
// - On output rises after input high delay
// - On-delay output drops immediately on low
// - Press must exceed minimum time, low-high-low
// - Latch on after full sequence, guard high
// - Guard low clears latch, new reset needed
// - Lamp blinks about 1Hz while guard high
// - Lamp can be enabled or disabled
// - Blink phases last 500 ms each
`default_nettype none

module timed_signal_functions #(
    parameter int CYCLES_PER_TICK = timed_signal_pkg::CYCLES_PER_MS // Clock cycles per ms
) (
    input wire logic aclk,                        // System clock, 50 MHz
    input wire logic aresetn,                     // Synchronous reset, active low
    input wire logic [31:0] s_axi_awaddr,         // Write address
    input wire logic s_axi_awvalid,               // Write address valid
    output logic s_axi_awready,                   // Write address ready
    input wire logic [31:0] s_axi_wdata,          // Write data
    input wire logic [3:0] s_axi_wstrb,           // Write byte strobes
    input wire logic s_axi_wvalid,                // Write data valid
    output logic s_axi_wready,                    // Write data ready
    output logic [1:0] s_axi_bresp,               // Write response
    output logic s_axi_bvalid,                    // Write response valid
    input wire logic s_axi_bready,                // Write response ready
    input wire logic [31:0] s_axi_araddr,         // Read address
    input wire logic s_axi_arvalid,               // Read address valid
    output logic s_axi_arready,                   // Read address ready
    output logic [31:0] s_axi_rdata,              // Read data
    output logic [1:0] s_axi_rresp,               // Read response
    output logic s_axi_rvalid,                    // Read data valid
    input wire logic s_axi_rready,                // Read data ready
    input wire timed_signal_pkg::fn_in_t fn_in,   // Function inputs
    output timed_signal_pkg::fn_out_t fn_out      // Function outputs
);
    import timed_signal_pkg::*;

    localparam int TICK_W = 32;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(CYCLES_PER_TICK - 1);

    // Millisecond prescaler
    logic [TICK_W-1:0] presc_q;
    logic tick_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            presc_q <= '0;
            tick_q <= 1'b0;
        end else if (presc_q >= TICK_LAST) begin
            presc_q <= '0;
            tick_q <= 1'b1;
        end else begin
            presc_q <= presc_q + 32'h0000_0001;
            tick_q <= 1'b0;
        end
    end

    // Configuration registers
    logic lamp_en_q;
    logic [TIME_W-1:0] off_delay_q;
    logic [TIME_W-1:0] on_delay_q;
    logic [TIME_W-1:0] min_push_q;

    // AXI write path: address and data are taken independently and held
    logic aw_held_q;
    logic [31:0] awaddr_q;
    logic w_held_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic do_write;
    logic wr_hit;

    assign do_write = aw_held_q && w_held_q && !bvalid_q;
    assign wr_hit = (awaddr_q == CTRL_OFFSET) || (awaddr_q == OFF_DELAY_OFFSET) ||
                    (awaddr_q == ON_DELAY_OFFSET) || (awaddr_q == MIN_PUSH_OFFSET) ||
                    (awaddr_q == STATUS_OFFSET);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            awaddr_q <= '0;
        end else if (s_axi_awvalid && awready_q) begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (s_axi_wvalid && wready_q) begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end else if (do_write) begin
            w_held_q <= 1'b0;
        end
    end

    // Ready is reopened only once the response has been taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b0;
            wready_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && awready_q) begin
                awready_q <= 1'b0;
            end else if (!aw_held_q && !bvalid_q) begin
                awready_q <= 1'b1;
            end
            if (s_axi_wvalid && wready_q) begin
                wready_q <= 1'b0;
            end else if (!w_held_q && !bvalid_q) begin
                wready_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Register writes honour byte strobes; the time fields use lanes 0 and 1
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lamp_en_q <= CTRL_LAMP_EN_RESET;
            off_delay_q <= OFF_DELAY_RESET;
            on_delay_q <= ON_DELAY_RESET;
            min_push_q <= MIN_PUSH_RESET;
        end else if (do_write) begin
            for (int b = 0; b < TIME_W / 8; b++) begin
                if (wstrb_q[b]) begin
                    if (awaddr_q == OFF_DELAY_OFFSET) begin
                        off_delay_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
                    end
                    if (awaddr_q == ON_DELAY_OFFSET) begin
                        on_delay_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
                    end
                    if (awaddr_q == MIN_PUSH_OFFSET) begin
                        min_push_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
                    end
                end
            end
            if (awaddr_q == CTRL_OFFSET && wstrb_q[0]) begin
                lamp_en_q <= wdata_q[CTRL_LAMP_EN_BIT];
            end
        end
    end

    // Function logic
    latch_state_t state_q;
    latch_state_t state_d;
    fn_out_t out_q;
    logic off_done;
    logic on_done;
    logic press_done;
    logic blink_done;
    logic blink_phase_q;
    logic blink_clr_q;

    ms_counter u_off_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(!fn_in.off_src),
        .tick(tick_q),
        .limit(off_delay_q),
        .done(off_done)
    );

    ms_counter u_on_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(fn_in.on_src),
        .tick(tick_q),
        .limit(on_delay_q),
        .done(on_done)
    );

    // Cleared whenever the button is low, so each press times from its own edge
    ms_counter u_press_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(fn_in.reset_btn && state_q == LATCH_PRESS),
        .tick(tick_q),
        .limit(min_push_q),
        .done(press_done)
    );

    ms_counter u_blink_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(fn_in.guard && !blink_clr_q),
        .tick(tick_q),
        .limit(BLINK_PHASE_TICKS),
        .done(blink_done)
    );

    // Restart goes through a flop; feeding done straight back into run would loop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            blink_clr_q <= 1'b0;
        end else begin
            blink_clr_q <= blink_done;
        end
    end

    // The press result is latched while the button is still high, since its timer clears on release
    logic press_ok_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            press_ok_q <= 1'b0;
        end else if (state_q != LATCH_PRESS) begin
            press_ok_q <= 1'b0;
        end else if (press_done) begin
            press_ok_q <= 1'b1;
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            LATCH_WAIT_LOW: begin
                if (fn_in.guard && !fn_in.reset_btn) begin
                    state_d = LATCH_READY;
                end
            end
            LATCH_READY: begin
                if (fn_in.reset_btn) begin
                    state_d = LATCH_PRESS;
                end
            end
            LATCH_PRESS: begin
                if (!fn_in.reset_btn) begin
                    state_d = (press_ok_q || press_done) ? LATCH_ON : LATCH_READY;
                end
            end
            LATCH_ON: begin
                state_d = LATCH_ON;
            end
            default: begin
                state_d = LATCH_WAIT_LOW;
            end
        endcase
        if (!fn_in.guard) begin
            state_d = LATCH_WAIT_LOW;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= LATCH_WAIT_LOW;
        end else begin
            state_q <= state_d;
        end
    end

    // Blink phase restarts high each time the guard rises
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            blink_phase_q <= 1'b1;
        end else if (!fn_in.guard) begin
            blink_phase_q <= 1'b1;
        end else if (blink_done) begin
            blink_phase_q <= !blink_phase_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_q <= '0;
        end else begin
            if (fn_in.off_src) begin
                out_q.off_dly <= 1'b1;
            end else if (off_done) begin
                out_q.off_dly <= 1'b0;
            end
            out_q.on_dly <= fn_in.on_src && (on_done || out_q.on_dly);
            out_q.latch <= (state_d == LATCH_ON);
            out_q.lamp <= lamp_en_q && fn_in.guard && blink_phase_q;
        end
    end

    assign fn_out = out_q;

    // AXI read path
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic [31:0] rd_word;
    logic rd_hit;

    always_comb begin
        rd_word = '0;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            CTRL_OFFSET: rd_word[CTRL_LAMP_EN_BIT] = lamp_en_q;
            OFF_DELAY_OFFSET: rd_word[TIME_W-1:0] = off_delay_q;
            ON_DELAY_OFFSET: rd_word[TIME_W-1:0] = on_delay_q;
            MIN_PUSH_OFFSET: rd_word[TIME_W-1:0] = min_push_q;
            STATUS_OFFSET: begin
                rd_word[STATUS_OUT_LSB +: 4] = out_q;
                rd_word[STATUS_IN_LSB +: 4] = fn_in;
                rd_word[STATUS_STATE_LSB +: 2] = state_q;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (s_axi_arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end else if (!rvalid_q) begin
            arready_q <= 1'b1;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
endmodule // timed_signal_functions

`default_nettype wire

// ==== timed_signal_pkg.sv ====
// Shared constants and carriers for the timed signal functions, plus the
// millisecond counter used by every timer in the block.
// Assumes one 50 MHz clock and a synchronous active-low reset.
`default_nettype none

package timed_signal_pkg;
    // Clock and tick timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int TICK_PERIOD_MS = 1;
    localparam int NS_PER_MS = 1000000;
    localparam int CYCLES_PER_MS = TICK_PERIOD_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int BLINK_PHASE_MS = 500;
    localparam logic [15:0] BLINK_PHASE_TICKS = 16'(BLINK_PHASE_MS / TICK_PERIOD_MS);

    // Register byte offsets
    localparam logic [31:0] CTRL_OFFSET = 32'h0000_0000;
    localparam logic [31:0] OFF_DELAY_OFFSET = 32'h0000_0004;
    localparam logic [31:0] ON_DELAY_OFFSET = 32'h0000_0008;
    localparam logic [31:0] MIN_PUSH_OFFSET = 32'h0000_000c;
    localparam logic [31:0] STATUS_OFFSET = 32'h0000_0010;

    // Field positions and widths
    localparam int CTRL_LAMP_EN_BIT = 0;
    localparam int TIME_W = 16;
    localparam int STATUS_OUT_LSB = 0;
    localparam int STATUS_IN_LSB = 4;
    localparam int STATUS_STATE_LSB = 8;

    // Reset values
    localparam logic CTRL_LAMP_EN_RESET = 1'b1;
    localparam logic [15:0] OFF_DELAY_RESET = 16'h0014;
    localparam logic [15:0] ON_DELAY_RESET = 16'h0014;
    localparam logic [15:0] MIN_PUSH_RESET = 16'h0064;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        LATCH_WAIT_LOW = 2'b00,
        LATCH_READY = 2'b01,
        LATCH_PRESS = 2'b10,
        LATCH_ON = 2'b11
    } latch_state_t;

    typedef struct packed {
        logic reset_btn; // Reset button of the latch
        logic guard;     // Guarded input of the latch
        logic on_src;    // Input of the on-delay
        logic off_src;   // Input of the off-delay
    } fn_in_t;

    typedef struct packed {
        logic lamp;      // Indicator lamp of the latch
        logic latch;     // Output of the latch
        logic on_dly;    // Output of the on-delay
        logic off_dly;   // Output of the off-delay
    } fn_out_t;
endpackage

// Counts millisecond ticks while run is high, clears at once when run drops.
// Saturates, so an unbounded run never wraps back under the limit.
module ms_counter
    import timed_signal_pkg::*;
(
    input wire logic aclk,                  // System clock
    input wire logic aresetn,               // Synchronous reset, active low
    input wire logic run,                   // Count while high, clear when low
    input wire logic tick,                  // One-millisecond pulse
    input wire logic [TIME_W-1:0] limit,    // Target time in ms
    output logic done                       // Run has lasted limit ms
);
    logic [TIME_W-1:0] cnt_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= '0;
        end else if (!run) begin
            cnt_q <= '0;
        end else if (tick && cnt_q != {TIME_W{1'b1}}) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    assign done = run && (cnt_q >= limit);
endmodule // ms_counter

`default_nettype wire

// ==== fn_source.sv ====
// Stand-in for the internal logic blocks that feed the function inputs.
// Levels change just after a clock edge, as a registered source would.
`default_nettype none

module fn_source
    import timed_signal_pkg::*;
(
    input wire logic aclk, // System clock
    input wire timed_signal_pkg::fn_in_t want, // Requested levels
    output timed_signal_pkg::fn_in_t fn_in = 4'h0 // Levels to the block
);
    always @(posedge aclk) begin
        fn_in <= want;
    end
endmodule // fn_source

`default_nettype wire

// ==== timed_signal_props.sv ====
// Checker for the timed signal functions, bound to the top module.
// Assumes function inputs are synchronous to aclk.
`default_nettype none

module timed_signal_props
    import timed_signal_pkg::*;
#(
    parameter int CYCLES_PER_TICK = timed_signal_pkg::CYCLES_PER_MS
) (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Reset, active low
    input wire logic s_axi_awvalid, // AW valid
    input wire logic s_axi_awready, // AW ready
    input wire logic s_axi_wvalid, // W valid
    input wire logic s_axi_wready, // W ready
    input wire logic [1:0] s_axi_bresp, // B response
    input wire logic s_axi_bvalid, // B valid
    input wire logic s_axi_bready, // B ready
    input wire logic s_axi_arvalid, // AR valid
    input wire logic s_axi_arready, // AR ready
    input wire logic [31:0] s_axi_rdata, // R data
    input wire logic [1:0] s_axi_rresp, // R response
    input wire logic s_axi_rvalid, // R valid
    input wire timed_signal_pkg::fn_in_t fn_in, // Function inputs
    input wire timed_signal_pkg::fn_out_t fn_out // Function outputs
);
    // Tick phase is free running, so a few cycles of slack on the phase
    localparam int LAMP_MAX = 500 * CYCLES_PER_TICK + 4;
    logic [31:0] hi_q;

    always_ff @(posedge aclk) begin
        if (!aresetn || !fn_out.lamp) begin
            hi_q <= 32'h0000_0000;
        end else begin
            hi_q <= hi_q + 32'h0000_0001;
        end
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    off_pass_a: assert property (fn_in.off_src |=> fn_out.off_dly)
        else $error("off delay output missed a rising input");
    off_hold_a: assert property ($fell(fn_out.off_dly) |->
        !$past(fn_in.off_src) && !$past(fn_in.off_src, 2))
        else $error("off delay output fell without a low input");
    on_drop_a: assert property (!fn_in.on_src |=> !fn_out.on_dly)
        else $error("on delay output stayed high after input low");
    on_hold_a: assert property ($rose(fn_out.on_dly) |->
        $past(fn_in.on_src) && $past(fn_in.on_src, 2))
        else $error("on delay output rose without a high input");
    guard_clr_a: assert property (!fn_in.guard |=> !fn_out.latch && !fn_out.lamp)
        else $error("latch or lamp high while guard low");
    latch_cause_a: assert property ($rose(fn_out.latch) |->
        $past(fn_in.guard) && !$past(fn_in.reset_btn))
        else $error("latch rose without release under guard");
    lamp_phase_a: assert property (hi_q <= LAMP_MAX)
        else $error("lamp high phase too long");
    wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    rd_err_a: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |->
        s_axi_rdata == 32'h0)
        else $error("error read returned data");
endmodule // timed_signal_props

bind timed_signal_functions timed_signal_props #(.CYCLES_PER_TICK(CYCLES_PER_TICK)) props (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .fn_in(fn_in), .fn_out(fn_out));

`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the timed signal functions.
// One 50 MHz clock; a short tick keeps the millisecond timers quick.
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import timed_signal_pkg::*;

    localparam int CPT = 2;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    fn_in_t want = 4'h0;
    fn_in_t fn_in;
    fn_out_t fn_out;
    int mismatches = 0;
    int samples_checked = 0;

    timed_signal_functions #(.CYCLES_PER_TICK(CPT)) DUT (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .fn_in(fn_in), .fn_out(fn_out));
    fn_source src (.aclk(aclk), .want(want), .fn_in(fn_in));

    initial begin
        forever #10 aclk = ~aclk;
    end

    task automatic end_sim();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
        @(posedge aclk);
    endtask

    task automatic axi_rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk(rdata, ed);
        chk({30'h0, rresp}, {30'h0, er});
        @(posedge aclk);
    endtask

    // Bits are {reset_btn, guard, on_src, off_src} in, {lamp, latch, on, off} out
    task automatic fn(input logic [3:0] w, input int n, input logic [3:0] e);
        want <= w;
        cyc(n);
        chk({28'h0, fn_out}, {28'h0, e});
    endtask

    initial begin
        cyc(3);
        aresetn <= 1'b1;
        cyc(2);
        axi_rd(CTRL_OFFSET, 32'h1, RESP_OKAY);
        axi_rd(OFF_DELAY_OFFSET, 32'h14, RESP_OKAY);
        axi_rd(ON_DELAY_OFFSET, 32'h14, RESP_OKAY);
        axi_rd(MIN_PUSH_OFFSET, 32'h64, RESP_OKAY);
        axi_rd(32'h20, 32'h0, RESP_SLVERR);
        axi_wr(32'h20, 32'h5, RESP_SLVERR);
        axi_wr(STATUS_OFFSET, 32'h0, RESP_OKAY);
        axi_wr(OFF_DELAY_OFFSET, 32'ha, RESP_OKAY);
        axi_wr(ON_DELAY_OFFSET, 32'ha, RESP_OKAY);
        axi_wr(MIN_PUSH_OFFSET, 32'ha, RESP_OKAY);
        axi_rd(OFF_DELAY_OFFSET, 32'ha, RESP_OKAY);
        fn(4'b0001, 3, 4'b0001);
        fn(4'b0000, 10, 4'b0001);
        fn(4'b0001, 3, 4'b0001);
        fn(4'b0000, 16, 4'b0001);
        fn(4'b0000, 10, 4'b0000);
        fn(4'b0010, 10, 4'b0000);
        fn(4'b0000, 3, 4'b0000);
        fn(4'b0010, 26, 4'b0010);
        fn(4'b0000, 3, 4'b0000);
        fn(4'b0100, 3, 4'b1000);
        fn(4'b1100, 10, 4'b1000);
        fn(4'b0100, 3, 4'b1000);
        fn(4'b1100, 26, 4'b1000);
        fn(4'b0100, 3, 4'b1100);
        axi_rd(STATUS_OFFSET, 32'h34c, RESP_OKAY);
        fn(4'b0000, 3, 4'b0000);
        fn(4'b0100, 4, 4'b1000);
        fn(4'b0100, 982, 4'b1000);
        fn(4'b0100, 24, 4'b0000);
        axi_wr(CTRL_OFFSET, 32'h0, RESP_OKAY);
        fn(4'b0100, 1100, 4'b0000);
        end_sim();
    end

    // Tests take about 2300 cycles; a hang is cut off well beyond that
    initial begin
        cyc(20000);
        mismatches++;
        end_sim();
    end
endmodule // tb_top

`default_nettype wire
